// ===== rtl/flash_address_space_protect.sv
// address decode and security-region guard for a serial flash
// assumes a command decoder presenting one request at a time, synchronous to clk
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "flash_guard_map.svh"
module flash_address_space_protect #(
   parameter logic [63:0]  UNIQUE_ID  = 64'h0123_4567_89AB_CDEF, // arbitrary value
   parameter logic [63:0]  ID_PREFIX  = 64'h1122_3344_5566_7788, // arbitrary value
   parameter logic [127:0] PARAM_HEAD = 128'hA5A5_0000_0000_0000_0000_0000_0000_5A5A // arbitrary
) (
   // clock and reset
   input  wire logic                         clk,
   input  wire logic                         reset_n,
   // register port
   input  wire logic [7:0]                   regAddr,
   input  wire logic [31:0]                  regWrData,
   input  wire logic                         regWrite,
   input  wire logic                         regRead,
   output logic      [31:0]                  regRdData,
   // operation request
   input  wire logic                         opValid,
   output logic                              opReady,
   input  wire flash_guard_pkg::op_kind_t    opKind,
   input  wire logic [7:0]                   opCmd,
   input  wire logic [31:0]                  opAddr,
   input  wire logic [7:0]                   opData,
   // operation answer
   output logic                              respValid,
   output logic                              respOk,
   output logic      [7:0]                   respData,
   // main array action
   output logic                              mainGo,
   output flash_guard_pkg::op_kind_t         mainKind,
   output logic      [31:0]                  mainBase,
   output logic      [`BLOCK_IDX_W-1:0]      blockIndex,
   output logic      [`HALF_IDX_W-1:0]       halfBlockIndex,
   output logic      [`SECTOR_IDX_W-1:0]     sectorIndex,
   // interrupt
   output logic                              irq
);
   import flash_guard_pkg::*;

   region_guard_if guard ();
   region_guard_check u_check (.guard(guard));

   guard_state_t             state_reg, state_next;
   logic [`SEC_ADDR_W-1:0]   wipePtr_reg, wipePtr_next;
   logic [7:0]               secMem [0:`SEC_BYTES-1];
   logic                     large_reg;
   logic [3:0]               configOnePersistent_reg;
   logic                     tempRegionGuardBit_reg;
   logic                     pwProtect_reg;
   logic                     readProtect_reg;
   logic                     pwAccepted_reg;
   logic [1:0]               statusTwoLive_reg, statusTwoLive_next;
   logic [`INT_BITS-1:0]     intStatus_reg, intStatus_next;
   logic [`INT_BITS-1:0]     intEnable_reg;
   logic [31:0]              regRdData_reg;
   logic                     respValid_reg, respOk_reg;
   logic [7:0]               respData_reg;
   logic                     mainGo_reg;
   op_kind_t                 mainKind_reg;
   logic [31:0]              mainBase_reg;
   logic [`BLOCK_IDX_W-1:0]  blockIndex_reg;
   logic [`HALF_IDX_W-1:0]   halfBlockIndex_reg;
   logic [`SECTOR_IDX_W-1:0] sectorIndex_reg;

   // guard settings to the checker
   assign guard.lockBits    = configOnePersistent_reg;
   assign guard.tempGuard   = tempRegionGuardBit_reg;
   assign guard.pwProtect   = pwProtect_reg;
   assign guard.readProtect = readProtect_reg;
   assign guard.pwAccepted  = pwAccepted_reg;

   // request decode
   wire opFire      = opValid & opReady;
   wire isMainRead  = (opKind == K_MAIN_READ);
   wire isMainProg  = (opKind == K_MAIN_PROG);
   wire isEraseSec  = (opKind == K_ERASE_SECTOR);
   wire isEraseHalf = (opKind == K_ERASE_HALF);
   wire isEraseBlk  = (opKind == K_ERASE_BLOCK);
   wire isSecRead   = (opKind == K_SEC_READ);
   wire isSecProg   = (opKind == K_SEC_PROG);
   wire isSecErase  = (opKind == K_SEC_ERASE);
   wire isIdRead    = (opKind == K_ID_READ);
   wire isParamRead = (opKind == K_PARAM_READ);
   wire isMainOp    = isMainRead | isMainProg | isEraseSec | isEraseHalf | isEraseBlk;
   wire isSecOp     = isSecRead | isSecProg | isSecErase;

   // main array geometry
   wire [31:0] lastAddr = large_reg ? `LARGE_LAST_ADDR : `SMALL_LAST_ADDR; // [RULE2] [RULE3]
   wire        inMain   = (opAddr <= lastAddr);
   wire [31:0] baseAddr = isEraseBlk  ? (opAddr & `BLOCK_MASK)  :
                          isEraseHalf ? (opAddr & `HALF_MASK)   :
                          isEraseSec  ? (opAddr & `SECTOR_MASK) : opAddr; // [RULE1]
   wire        mainStart = opFire & isMainOp & inMain & ~isMainRead;

   // security space addressing
   wire [`SEC_ADDR_W-1:0] secAddr = opAddr[`SEC_ADDR_W-1:0];
   wire [1:0] region  = secAddr[`REGION_LO +: 2]; // [RULE16]
   wire       inSec   = (opAddr[31:`SEC_ADDR_W] == '0); // [RULE7]
   wire       wrBlock = guard.writeBlocked[region];
   wire       rdBlock = guard.readBlocked[region];
   wire       secProgOk  = opFire & isSecProg & inSec & ~wrBlock; // [RULE9]
   wire       secEraseOk = opFire & isSecErase & inSec & ~wrBlock; // [RULE9]

   // identification and parameter spaces: constants, no write path exists
   wire [127:0] idSpace    = {UNIQUE_ID, ID_PREFIX}; // [RULE4] [RULE5]
   wire [255:0] paramSpace = {idSpace, PARAM_HEAD}; // [RULE6]
   wire [7:0]   idByte     = idSpace[{opAddr[`ID_ADDR_W-1:0], 3'b000} +: 8];
   wire [7:0]   paramByte  = paramSpace[{opAddr[`PARAM_ADDR_W-1:0], 3'b000} +: 8];
   wire         idOk    = (opCmd == `CMD_READ_ID) & (opAddr[31:`ID_ADDR_W] == '0);
   wire         paramOk = (opCmd == `CMD_READ_PARAMS) & (opAddr[31:`PARAM_ADDR_W] == '0);

   // events
   wire evProgFail  = opFire & isSecProg & inSec & wrBlock; // [RULE15]
   wire evEraseFail = opFire & isSecErase & inSec & wrBlock; // [RULE15]
   wire evReadBlock = opFire & isSecRead & inSec & rdBlock; // [RULE14]
   wire wipeLast    = (state_reg == ST_WIPE) & (wipePtr_reg[`REGION_LO-1:0] == '1);
   wire initLast    = (state_reg == ST_INIT) & (wipePtr_reg == '1);
   wire [`INT_BITS-1:0] events = {wipeLast, evReadBlock, evEraseFail, evProgFail};

   // answer selection
   wire [7:0] secByte = secMem[secAddr];
   wire answerOk = (isMainOp & inMain) | (isSecRead & inSec & ~rdBlock)
                 | secProgOk | secEraseOk | (isIdRead & idOk) | (isParamRead & paramOk);
   wire [7:0] answerData = isSecRead   ? (rdBlock ? `UNDEF_BYTE : secByte) : // [RULE14]
                           isIdRead    ? (idOk ? idByte : `SEC_ERASED) :
                           isParamRead ? (paramOk ? paramByte : `SEC_ERASED) :
                           `SEC_ERASED;

   // security memory write port: wiping writes the erased value, program only clears bits
   wire                   wiping = (state_reg == ST_INIT) | (state_reg == ST_WIPE);
   wire                   memWe  = wiping | secProgOk; // [RULE15]
   wire [`SEC_ADDR_W-1:0] memWa  = wiping ? wipePtr_reg : secAddr;
   wire [7:0]             memWd  = wiping ? `SEC_ERASED : (secByte & opData); // [RULE8]

   always_ff @(posedge clk) begin
      if (memWe) begin
         secMem[memWa] <= memWd;
      end
   end

   // sequencing: reset wipes the whole space, region erase wipes 256 bytes
   always_comb begin
      state_next   = state_reg;
      wipePtr_next = wipePtr_reg + 1'b1;
      unique case (state_reg)
         ST_INIT: begin
            if (initLast) begin
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            wipePtr_next = {region, {`REGION_LO{1'b0}}};
            if (secEraseOk) begin
               state_next = ST_WIPE; // [RULE9]
            end
         end
         ST_WIPE: begin
            if (wipeLast) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_INIT;
         end
      endcase
   end

   // busy while wiping; requests wait
   assign opReady = (state_reg == ST_IDLE);

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         state_reg   <= ST_INIT;
         wipePtr_reg <= '0;
      end else begin
         state_reg   <= state_next;
         wipePtr_reg <= wipePtr_next;
      end
   end

   // answer and main array outputs
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         respValid_reg <= 1'b0;
         respOk_reg    <= 1'b0;
         respData_reg  <= '0;
         mainGo_reg    <= 1'b0;
      end else begin
         respValid_reg <= opFire;
         respOk_reg    <= opFire & answerOk;
         respData_reg  <= answerData;
         mainGo_reg    <= mainStart;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         mainKind_reg       <= K_MAIN_READ;
         mainBase_reg       <= '0;
         blockIndex_reg     <= '0;
         halfBlockIndex_reg <= '0;
         sectorIndex_reg    <= '0;
      end else if (opFire & isMainOp) begin
         mainKind_reg       <= opKind;
         mainBase_reg       <= baseAddr;
         blockIndex_reg     <= opAddr[`BLOCK_SHIFT +: `BLOCK_IDX_W]; // [RULE1]
         halfBlockIndex_reg <= opAddr[`HALF_SHIFT +: `HALF_IDX_W];
         sectorIndex_reg    <= opAddr[`SECTOR_SHIFT +: `SECTOR_IDX_W];
      end
   end

   // register writes
   wire wrCtrl   = regWrite & (regAddr == `OFF_CTRL);
   wire wrConfig = regWrite & (regAddr == `OFF_CONFIG_ONE);
   wire wrLatch  = regWrite & (regAddr == `OFF_GUARD_LATCH);
   wire wrGuard  = regWrite & (regAddr == `OFF_REGION_GUARD);
   wire wrUnlock = regWrite & (regAddr == `OFF_UNLOCK);
   wire wrStat2  = regWrite & (regAddr == `OFF_STATUS_TWO);
   wire wrIntClr = regWrite & (regAddr == `OFF_INT_CLEAR);
   wire wrIntEn  = regWrite & (regAddr == `OFF_INT_ENABLE);

   // fail flags and interrupt status: a new event beats a clear in the same cycle
   wire [1:0] stat2Clr = wrStat2 ? {regWrData[`PROG_FAIL_BIT], regWrData[`ERASE_FAIL_BIT]} : 2'h0;
   assign statusTwoLive_next = (statusTwoLive_reg & ~stat2Clr)
                             | {evProgFail, evEraseFail}; // [RULE15]
   assign intStatus_next = (intStatus_reg & ~(wrIntClr ? regWrData[`INT_BITS-1:0] : '0))
                         | events;

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         large_reg               <= `CTRL_RESET;
         configOnePersistent_reg <= '0;
         tempRegionGuardBit_reg  <= 1'b0;
         pwProtect_reg           <= 1'b0;
         readProtect_reg         <= 1'b0;
         pwAccepted_reg          <= 1'b0;
         statusTwoLive_reg       <= '0;
         intStatus_reg           <= '0;
         intEnable_reg           <= '0;
      end else begin
         statusTwoLive_reg <= statusTwoLive_next;
         intStatus_reg     <= intStatus_next;
         if (wrCtrl) begin
            large_reg <= regWrData[`CTRL_LARGE_BIT];
         end
         if (wrConfig) begin
            // one-time bits: writes can only set them
            configOnePersistent_reg <= configOnePersistent_reg
                                     | regWrData[`LOCK_HI:`LOCK_LO]; // [RULE10]
         end
         if (wrLatch) begin
            tempRegionGuardBit_reg <= regWrData[`TEMP_GUARD_BIT]; // [RULE11]
         end
         if (wrGuard) begin
            pwProtect_reg   <= regWrData[`PW_PROTECT_BIT]; // [RULE12]
            readProtect_reg <= regWrData[`READ_PROTECT_BIT]; // [RULE13]
         end
         if (wrUnlock) begin
            pwAccepted_reg <= regWrData[`PW_OK_BIT];
         end
         if (wrIntEn) begin
            intEnable_reg <= regWrData[`INT_BITS-1:0];
         end
      end
   end

   // register reads; unmapped and write-only offsets read zero
   logic [31:0] rdMux;
   always_comb begin
      rdMux = '0;
      case (regAddr)
         `OFF_CTRL:         rdMux[`CTRL_LARGE_BIT] = large_reg;
         `OFF_CONFIG_ONE:   rdMux[`LOCK_HI:`LOCK_LO] = configOnePersistent_reg;
         `OFF_GUARD_LATCH:  rdMux[`TEMP_GUARD_BIT] = tempRegionGuardBit_reg;
         `OFF_REGION_GUARD: begin
            rdMux[`PW_PROTECT_BIT]   = pwProtect_reg;
            rdMux[`READ_PROTECT_BIT] = readProtect_reg;
         end
         `OFF_UNLOCK:       rdMux[`PW_OK_BIT] = pwAccepted_reg;
         `OFF_STATUS_TWO: begin
            rdMux[`PROG_FAIL_BIT]  = statusTwoLive_reg[1];
            rdMux[`ERASE_FAIL_BIT] = statusTwoLive_reg[0];
         end
         `OFF_INT_STATUS:   rdMux[`INT_BITS-1:0] = intStatus_reg;
         `OFF_INT_ENABLE:   rdMux[`INT_BITS-1:0] = intEnable_reg;
         `OFF_UID_LO:       rdMux = UNIQUE_ID[31:0]; // [RULE5]
         `OFF_UID_HI:       rdMux = UNIQUE_ID[63:32]; // [RULE5]
         default:           rdMux = '0;
      endcase
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         regRdData_reg <= '0;
      end else begin
         regRdData_reg <= regRead ? rdMux : '0;
      end
   end

   assign regRdData      = regRdData_reg;
   assign respValid      = respValid_reg;
   assign respOk         = respOk_reg;
   assign respData       = respData_reg;
   assign mainGo         = mainGo_reg;
   assign mainKind       = mainKind_reg;
   assign mainBase       = mainBase_reg;
   assign blockIndex     = blockIndex_reg;
   assign halfBlockIndex = halfBlockIndex_reg;
   assign sectorIndex    = sectorIndex_reg;
   assign irq            = |(intStatus_reg & intEnable_reg);

   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   property p_sector_align;
      opFire && isEraseSec && inMain |=> mainGo && mainBase[11:0] == 12'h000;
   endproperty
   a_sector_align: assert property (p_sector_align) // [RULE1]
      else $error("sector erase base not aligned");

   property p_large_span;
      opFire && isMainOp && large_reg && opAddr > 32'h01FFFFFF |=> respValid && !respOk;
   endproperty
   a_large_span: assert property (p_large_span) // [RULE2]
      else $error("large variant accepted address past end");

   property p_small_span;
      opFire && isMainOp && !large_reg && opAddr == 32'h00FFF000 |=> respOk
         && sectorIndex == 13'h0FFF;
   endproperty
   a_small_span: assert property (p_small_span) // [RULE3]
      else $error("small variant last sector wrong");

   property p_id_read;
      opFire && isIdRead && idOk |=> respOk && respData == $past(idByte);
   endproperty
   a_id_read: assert property (p_id_read) // [RULE4]
      else $error("identification read wrong");

   property p_uid_reg;
      regRead && regAddr == `OFF_UID_HI |=> regRdData == UNIQUE_ID[63:32];
   endproperty
   a_uid_reg: assert property (p_uid_reg) // [RULE5]
      else $error("unique id register wrong");

   property p_param_embed;
      opFire && isParamRead && paramOk && opAddr[4] |=> respData == $past(idByte);
   endproperty
   a_param_embed: assert property (p_param_embed) // [RULE6]
      else $error("parameter space does not embed id");

   property p_wipe_len;
      secEraseOk |=> !opReady [*8] ##248 !opReady ##1 opReady;
   endproperty
   a_wipe_len: assert property (p_wipe_len) // [RULE9]
      else $error("region erase length wrong");

   property p_prog_fail;
      opFire && isSecProg && inSec && guard.writeBlocked[opAddr[9:8]] |=>
         statusTwoLive_reg[1] && secMem[$past(secAddr)] == $past(secByte);
   endproperty
   a_prog_fail: assert property (p_prog_fail) // [RULE15]
      else $error("blocked program not flagged");

   property p_lock_erase;
      opFire && isSecErase && inSec && configOnePersistent_reg[opAddr[9:8]] |=>
         statusTwoLive_reg[0] && opReady;
   endproperty
   a_lock_erase: assert property (p_lock_erase) // [RULE10]
      else $error("locked region erase not refused");

   property p_read_block;
      opFire && isSecRead && inSec && opAddr[9:8] == 2'h3 && readProtect_reg
         && !pwAccepted_reg |=> respData == `UNDEF_BYTE && !respOk;
   endproperty
   a_read_block: assert property (p_read_block) // [RULE13]
      else $error("protected region 3 read leaked");
endmodule

// ===== rtl/flash_guard_map.svh
// offsets, field positions, reset values and geometry of the flash guard block
// assumes a 32-bit register port with byte offsets on an 8-bit address
// What this block does
// RULE1 - main array erases in aligned 64 KB blocks, 32 KB halves, 4 KB sectors
// RULE2 - large variant spans to 1FFFFFFh: 512 blocks, 1024 halves, 8192 sectors
// RULE3 - small variant spans to FFFFFFh: 256 blocks, 512 halves, 4096 sectors
// RULE4 - command 9Fh reads a factory identification space that is never writable
// RULE5 - identification space holds an 8-byte unique serial number
// RULE6 - command 5Ah reads a read-only parameter space embedding the identification data
// RULE7 - 1024-byte security space, four separately lockable regions of 256 bytes
// RULE8 - regions sit at 000, 100, 200, 300; every byte starts as FFh
// RULE9 - unguarded regions program and erase like flash, each erased alone
// RULE10 - one-time lock bits 5..2 of persistent config permanently block their region; reset_n clears them here
// RULE11 - volatile temporary guard bit blocks program and erase of regions 2 and 3
// RULE12 - guard bit 2 blocks program and erase of regions 2, 3 until password
// RULE13 - guard bit 6 also blocks reads of region 3 until password
// RULE14 - a blocked read returns undefined data, never the stored bytes
// RULE15 - blocked program or erase changes nothing and sets fail bit 6 or 5
// RULE16 - region index comes from security address bits 9 and 8
`ifndef FLASH_GUARD_MAP_SVH
`define FLASH_GUARD_MAP_SVH

`define OFF_CTRL         8'h00
`define OFF_CONFIG_ONE   8'h04
`define OFF_GUARD_LATCH  8'h08
`define OFF_REGION_GUARD 8'h0C
`define OFF_UNLOCK       8'h10
`define OFF_STATUS_TWO   8'h14
`define OFF_INT_STATUS   8'h18
`define OFF_INT_CLEAR    8'h1C
`define OFF_INT_ENABLE   8'h20
`define OFF_UID_LO       8'h24
`define OFF_UID_HI       8'h28

`define CTRL_LARGE_BIT   0
`define CTRL_RESET       1'h1
`define LOCK_LO          2
`define LOCK_HI          5
`define TEMP_GUARD_BIT   0
`define PW_PROTECT_BIT   2
`define READ_PROTECT_BIT 6
`define PW_OK_BIT        0
`define PROG_FAIL_BIT    6
`define ERASE_FAIL_BIT   5
`define INT_BITS         4
`define INT_PROG_FAIL    0
`define INT_ERASE_FAIL   1
`define INT_READ_BLOCK   2
`define INT_WIPE_DONE    3

`define LARGE_LAST_ADDR  32'h01FFFFFF
`define SMALL_LAST_ADDR  32'h00FFFFFF
`define BLOCK_MASK       32'hFFFF0000
`define HALF_MASK        32'hFFFF8000
`define SECTOR_MASK      32'hFFFFF000
`define BLOCK_SHIFT      16
`define HALF_SHIFT       15
`define SECTOR_SHIFT     12
`define BLOCK_IDX_W      9
`define HALF_IDX_W       10
`define SECTOR_IDX_W     13

`define SEC_ADDR_W       10
`define SEC_BYTES        1024
`define REGION_LO        8
`define SEC_ERASED       8'hFF
`define UNDEF_BYTE       8'h00
`define ID_ADDR_W        4
`define PARAM_ADDR_W     5

`define CMD_READ_ID      8'h9F
`define CMD_READ_PARAMS  8'h5A

`endif

// ===== rtl/flash_guard_pkg.sv
// types shared by the flash guard modules
// assumes nothing beyond a SystemVerilog compiler
package flash_guard_pkg;
   typedef enum logic [9:0] {
      K_MAIN_READ    = 10'h001,
      K_MAIN_PROG    = 10'h002,
      K_ERASE_SECTOR = 10'h004,
      K_ERASE_HALF   = 10'h008,
      K_ERASE_BLOCK  = 10'h010,
      K_SEC_READ     = 10'h020,
      K_SEC_PROG     = 10'h040,
      K_SEC_ERASE    = 10'h080,
      K_ID_READ      = 10'h100,
      K_PARAM_READ   = 10'h200
   } op_kind_t;
   typedef enum logic [2:0] {
      ST_INIT = 3'h1,
      ST_IDLE = 3'h2,
      ST_WIPE = 3'h4
   } guard_state_t;
endpackage

// ===== rtl/region_guard_if.sv
// guard settings in, per-region blocking out
// assumes both ends share one clock domain
`timescale 1ns/1ps
interface region_guard_if;
   logic [3:0] lockBits;
   logic       tempGuard;
   logic       pwProtect;
   logic       readProtect;
   logic       pwAccepted;
   logic [3:0] writeBlocked;
   logic [3:0] readBlocked;
   modport owner (output lockBits, tempGuard, pwProtect, readProtect, pwAccepted,
                  input writeBlocked, readBlocked);
   modport judge (input lockBits, tempGuard, pwProtect, readProtect, pwAccepted,
                  output writeBlocked, readBlocked);
endinterface

// ===== rtl/region_guard_check.sv
// per-region program/erase and read blocking decision
// assumes guard settings are stable registers of the owner
`timescale 1ns/1ps
module region_guard_check (
   // guard settings and verdicts
   region_guard_if.judge guard
);
   genvar r;
   generate
      for (r = 0; r < 4; r++) begin : g_region
         // only the upper two regions take the temporary and password guards
         wire upper = (r >= 2);
         wire pwHold = guard.pwProtect & ~guard.pwAccepted;
         assign guard.writeBlocked[r] = guard.lockBits[r]         // [RULE10]
                                      | (upper & guard.tempGuard) // [RULE11]
                                      | (upper & pwHold);         // [RULE12]
         assign guard.readBlocked[r]  = (r == 3) & guard.readProtect
                                      & ~guard.pwAccepted;        // [RULE13]
      end
   endgenerate
endmodule

// ===== tb/host_cmd_model.sv
// host command model: one op request at a time on the op port
// assumes the block registers its answer on the same edge that takes a request
`timescale 1ns/1ps
module host_cmd_model (
   // clock and handshake
   input  wire logic                 clk,
   input  wire logic                 opReady,
   // request
   output logic                      opValid,
   output flash_guard_pkg::op_kind_t opKind,
   output logic      [7:0]           opCmd,
   output logic      [31:0]          opAddr,
   output logic      [7:0]           opData
);
   import flash_guard_pkg::*;
   initial begin
      opValid = 1'b0;
      opKind = K_MAIN_READ;
      opCmd = 8'h00;
      opAddr = 32'h0;
      opData = 8'h00;
   end
   // id and param spaces only ever read, never written
   task automatic op(input op_kind_t k, input logic [7:0] c, input logic [31:0] a,
                     input logic [7:0] d);
      int n;
      @(posedge clk);
      opValid <= 1'b1;
      opKind <= k;
      opCmd <= c;
      opAddr <= a;
      opData <= d;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (opReady !== 1'b1 && n < 2000);
      opValid <= 1'b0;
      // released address and data lines flip so stale values cannot pass; kind and command hold
      opAddr <= ~a;
      opData <= ~d;
      #1;
   endtask
endmodule

// ===== tb/flash_address_space_protect_test.sv
// self-checking bench for the flash guard block
// assumes host_cmd_model drives the op port, bench drives registers
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_fail++; \
   $display("[FAIL] %0t mismatch", $time); end end
module flash_address_space_protect_test;
   import flash_guard_pkg::*;
   localparam logic [63:0] UID = 64'hFEDC_BA98_7654_3210; // arbitrary value
   logic clk, reset_n, regWrite, regRead, opValid, opReady, respValid, respOk, mainGo, irq;
   logic [7:0] regAddr, opCmd, opData, respData;
   logic [31:0] regWrData, regRdData, opAddr, mainBase, a;
   logic [8:0] blockIndex;
   logic [9:0] halfBlockIndex;
   logic [12:0] sectorIndex;
   op_kind_t opKind, mainKind;
   int n_fail, samples_checked, o, secMem[1024];
   int shs[3] = '{16, 15, 12};
   op_kind_t ks[3] = '{K_ERASE_BLOCK, K_ERASE_HALF, K_ERASE_SECTOR};
   flash_address_space_protect #(.UNIQUE_ID(UID)) dut (.clk, .reset_n, .regAddr, .regWrData,
      .regWrite, .regRead, .regRdData, .opValid, .opReady, .opKind, .opCmd, .opAddr, .opData,
      .respValid, .respOk, .respData, .mainGo, .mainKind, .mainBase, .blockIndex,
      .halfBlockIndex, .sectorIndex, .irq);
   host_cmd_model m (.clk, .opReady, .opValid, .opKind, .opCmd, .opAddr, .opData);
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   task end_of_test;
      $display("checked %0d failed %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   task wr(input logic [7:0] ad, input logic [31:0] d);
      @(posedge clk);
      regAddr <= ad;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clk);
      regWrite <= 1'b0;
      #1;
   endtask
   task rdc(input logic [7:0] ad, input logic [31:0] e);
      @(posedge clk);
      regAddr <= ad;
      regRead <= 1'b1;
      @(posedge clk);
      regRead <= 1'b0;
      #1;
      `CHK(regRdData, e)
   endtask
   task sop(input op_kind_t k, input logic [31:0] ad, input logic [7:0] d, input logic ok,
            input logic [7:0] e);
      m.op(k, 8'h00, ad, d);
      `CHK(respValid, 1'b1)
      `CHK(respOk, ok)
      `CHK(respData, e)
   endtask
   initial begin
      #40000;
      n_fail++;
      end_of_test;
   end
   initial begin
      reset_n = 1'b0;
      regAddr = 8'h00;
      regWrData = 32'h0;
      regWrite = 1'b0;
      regRead = 1'b0;
      void'($urandom(32'h37C8));
      for (int i = 0; i < 1024; i++) secMem[i] = 255;
      repeat (2) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
      #1 `CHK(opReady, 1'b0)
      rdc(`OFF_UID_LO, UID[31:0]);
      rdc(`OFF_UID_HI, UID[63:32]);
      rdc(8'hF0, 32'h0);
      for (int i = 8; i < 16; i++) begin
         m.op(K_ID_READ, `CMD_READ_ID, i, 8'h00);
         `CHK(respData, UID[8*(i-8)+:8])
         m.op(K_PARAM_READ, `CMD_READ_PARAMS, i + 16, 8'h00);
         `CHK(respData, UID[8*(i-8)+:8])
      end
      $display("ident test done");
      for (int k = 0; k < 3; k++) begin
         a = $urandom & 32'h01FFFFFF;
         m.op(ks[k], 8'h00, a, 8'h00);
         `CHK(mainGo, 1'b1)
         `CHK(mainKind, ks[k])
         `CHK(mainBase, a & ~((32'h1 << shs[k]) - 32'h1))
         `CHK({blockIndex, halfBlockIndex, sectorIndex}, {a[24:16], a[24:15], a[24:12]})
      end
      m.op(K_MAIN_PROG, 8'h00, a, 8'h00);
      `CHK({mainGo, mainKind, mainBase}, {1'b1, K_MAIN_PROG, a})
      m.op(K_ERASE_SECTOR, 8'h00, 32'h01FFF000, 8'h00);
      `CHK({mainGo, sectorIndex}, {1'b1, 13'd8191})
      m.op(K_ERASE_SECTOR, 8'h00, 32'h02000000, 8'h00);
      `CHK(mainGo, 1'b0)
      wr(`OFF_CTRL, 32'h0);
      m.op(K_ERASE_SECTOR, 8'h00, 32'h01000000, 8'h00);
      `CHK(mainGo, 1'b0)
      sop(K_MAIN_READ, 32'h01000000, 8'h00, 1'b0, 8'hFF);
      sop(K_MAIN_READ, 32'h00FFFFFF, 8'h00, 1'b1, 8'hFF);
      m.op(K_ERASE_SECTOR, 8'h00, 32'h00FFF000, 8'h00);
      `CHK({mainGo, sectorIndex}, {1'b1, 13'd4095})
      $display("main array test done");
      wr(`OFF_INT_ENABLE, 32'hF);
      o = $urandom & 32'hFF;
      sop(K_SEC_PROG, o, 8'h5A, 1'b1, 8'hFF);
      secMem[o] &= 8'h5A;
      sop(K_SEC_READ, o, 8'h00, 1'b1, secMem[o][7:0]);
      sop(K_SEC_READ, 32'h3FF, 8'h00, 1'b1, 8'hFF);
      m.op(K_SEC_READ, 8'h00, 32'h400, 8'h00);
      `CHK(respOk, 1'b0)
      wr(`OFF_CONFIG_ONE, 32'h8);
      wr(`OFF_CONFIG_ONE, 32'h0);
      rdc(`OFF_CONFIG_ONE, 32'h8);
      sop(K_SEC_PROG, 32'h100 | o, 8'h00, 1'b0, 8'hFF);
      rdc(`OFF_STATUS_TWO, 32'h40);
      `CHK(irq, 1'b1)
      sop(K_SEC_ERASE, 32'h100, 8'h00, 1'b0, 8'hFF);
      `CHK(opReady, 1'b1)
      sop(K_SEC_READ, 32'h100 | o, 8'h00, 1'b1, 8'hFF);
      wr(`OFF_INT_CLEAR, 32'hF);
      wr(`OFF_STATUS_TWO, 32'h60);
      `CHK(irq, 1'b0)
      wr(`OFF_GUARD_LATCH, 32'h1);
      sop(K_SEC_ERASE, 32'h200, 8'h00, 1'b0, 8'hFF);
      rdc(`OFF_STATUS_TWO, 32'h20);
      wr(`OFF_GUARD_LATCH, 32'h0);
      wr(`OFF_REGION_GUARD, 32'h44);
      sop(K_SEC_PROG, 32'h300 | o, 8'h00, 1'b0, 8'hFF);
      m.op(K_SEC_READ, 8'h00, 32'h300 | o, 8'h00);
      `CHK(respData, 8'h00)
      rdc(`OFF_INT_STATUS, 32'h7);
      wr(`OFF_UNLOCK, 32'h1);
      sop(K_SEC_READ, 32'h300 | o, 8'h00, 1'b1, 8'hFF);
      $display("guard test done");
      wr(`OFF_INT_CLEAR, 32'hF);
      sop(K_SEC_ERASE, o, 8'h00, 1'b1, 8'hFF);
      secMem[o] = 255;
      `CHK(opReady, 1'b0)
      sop(K_SEC_READ, o, 8'h00, 1'b1, secMem[o][7:0]);
      rdc(`OFF_INT_STATUS, 32'h8);
      $display("region erase test done");
      end_of_test;
   end
endmodule
